// file: verilog/pit_map.svh
`ifndef PIT_MAP_SVH
`define PIT_MAP_SVH

// ---------------------------------------------------------------------------
// Port addresses
// ---------------------------------------------------------------------------
`define PIT_ADDR_CONTROL_WORD_REGISTER 2'h3

// ---------------------------------------------------------------------------
// Control word fields
// ---------------------------------------------------------------------------
`define CW_SC_HI   7
`define CW_SC_LO   6
`define CW_RW_HI   5
`define CW_RW_LO   4
`define CW_CFG_HI  5
`define CW_CFG_LO  0
`define CW_SC_READBACK 2'h3
`define RB_NO_COUNT_BIT  5
`define RB_NO_STATUS_BIT 4
`define RB_SEL_LO        1

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define CTL_RESET   6'h00
`define COUNT_RESET 16'h0000
`define BYTE_ZERO   8'h00

`endif

// file: verilog/pit_pkg.sv
package pit_pkg;
  typedef logic [15:0] count_t;
  typedef logic [7:0]  byte_t;
  typedef logic [5:0]  ctl_t;
  typedef enum logic [1:0] {
    RW_LATCH = 2'h0,
    RW_LSB   = 2'h1,
    RW_MSB   = 2'h2,
    RW_LH    = 2'h3
  } rw_t;
endpackage

// file: verilog/pit_element.sv
`timescale 1ns/1ps
`include "pit_map.svh"

module pit_element (
  input  wire logic            i_clk,
  input  wire logic            i_rstn,
  input  wire logic            i_cnt_clk,
  input  wire logic            i_gate,
  input  wire logic            i_arm,
  input  wire logic            i_load,
  input  wire pit_pkg::count_t i_cr,
  output pit_pkg::count_t      o_count,
  output logic                 o_out,
  output logic                 o_null
);
  import pit_pkg::*;

  logic   cnt_clk_r;
  logic   cnt_clk_nxt;
  count_t count_r;
  count_t count_nxt;
  logic   pend_r;
  logic   pend_nxt;
  logic   out_r;
  logic   out_nxt;
  logic   tick;

  // ---------------------------------------------------------------------------
  // Counting element
  // ---------------------------------------------------------------------------
  // A written count only waits in the count register; it reaches the element
  // on the next rising edge of the counter's own clock, both bytes at once.
  always_comb begin
    cnt_clk_nxt = i_cnt_clk;
    tick        = i_cnt_clk & ~cnt_clk_r;
    count_nxt   = count_r;
    out_nxt     = out_r;
    pend_nxt    = pend_r | i_load;
    if (tick && pend_r) begin
      count_nxt = i_cr;
      pend_nxt  = i_load;
    end else if (tick && i_gate) begin
      count_nxt = count_r - 16'h0001;
      if (count_r == 16'h0001) begin
        out_nxt = 1'b1;
      end
    end
    if (i_arm) begin
      out_nxt  = 1'b0;
      pend_nxt = 1'b0;
    end
  end

  // The element has no defined power-up value; reset clears it for repeatability.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_clk_r <= 1'b0;
      count_r   <= `COUNT_RESET;
      pend_r    <= 1'b0;
      out_r     <= 1'b0;
    end else begin
      cnt_clk_r <= cnt_clk_nxt;
      count_r   <= count_nxt;
      pend_r    <= pend_nxt;
      out_r     <= out_nxt;
    end
  end

  assign o_count = count_r;
  assign o_out   = out_r;
  assign o_null  = pend_r;
endmodule

// file: verilog/pit_top.sv
// What this block does
// - A write to port three stores a control word that configures counters.
// - Read and write strobes do nothing unless chip select is low.
// - Control register is write-only; status comes only via read-back.
// - Three identical counters run independently, each in its own mode.
// - Each counting element is a 16-bit loadable down counter.
// - Output latch follows the element, freezes on latch, resumes after read.
// - Only one latch byte reaches the data bus per read.
// - Count reads always return the output latch, never the element.
// - Each write loads exactly one byte of the count register.
// - Count waits in count register, then moves to element whole.
// - One-byte formats leave the unwritten count register byte zero.
// - Host count writes reach only the count register.
// - Latched status holds control bits, output level and null count.
// - No defined power-up state for mode, count or output; here reset clears all three to zero.
// - Each control word names its own counter, in any order.
// - Counts go to the counter's own port, decoded by its format.
// - Data port is three-state, driven only during selected reads.
// - Select field picks counter 0..2; all-ones means read-back.
// - Format field selects low only, high only, or low then high.
// - Latch command freezes the counter's output latch, mode unchanged.
`timescale 1ns/1ps
`include "pit_map.svh"

module pit_top #(
  parameter int NUM_CNT = 3
) (
  input  wire logic               I_CLK,
  input  wire logic               I_RSTN,
  input  wire logic               I_CS_N,
  input  wire logic               I_RD_N,
  input  wire logic               I_WR_N,
  input  wire logic               I_PORT_SELECT_LSB,
  input  wire logic               I_PORT_SELECT_MSB,
  input  wire pit_pkg::byte_t     I_HOST_DATA_BUS,
  output pit_pkg::byte_t          O_HOST_DATA_BUS,
  output logic                    O_HOST_DATA_BUS_OE_N,
  input  wire logic [NUM_CNT-1:0] I_CNT_CLK,
  input  wire logic [NUM_CNT-1:0] I_GATE,
  output logic [NUM_CNT-1:0]      O_OUT
);
  import pit_pkg::*;

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic hits(input logic [1:0] port, input int idx);
    hits = (int'(port) == idx);
  endfunction

  function automatic byte_t pick(input count_t v, input logic hi);
    pick = hi ? v[15:8] : v[7:0];
  endfunction

  logic [1:0] port;
  logic       wr_n_r;
  logic       wr_n_nxt;
  logic       wr_evt;
  logic       rd_now;
  logic       rd_act_r;
  logic       rd_act_nxt;
  logic [1:0] rd_port_r;
  logic [1:0] rd_port_nxt;
  logic       rd_done;
  logic       cw_evt;
  logic [1:0] cw_sc;
  rw_t        cw_rw;
  byte_t      dout_r;
  byte_t      dout_nxt;
  logic       oe_n_r;
  logic       oe_n_nxt;

  ctl_t   ctl_r    [NUM_CNT];
  ctl_t   ctl_nxt  [NUM_CNT];
  count_t cr_r     [NUM_CNT];
  count_t cr_nxt   [NUM_CNT];
  count_t ol_r     [NUM_CNT];
  count_t ol_nxt   [NUM_CNT];
  byte_t  st_r     [NUM_CNT];
  byte_t  st_nxt   [NUM_CNT];
  count_t cnt      [NUM_CNT];
  byte_t  rbyte    [NUM_CNT];
  logic [NUM_CNT-1:0] latched_r;
  logic [NUM_CNT-1:0] latched_nxt;
  logic [NUM_CNT-1:0] st_vld_r;
  logic [NUM_CNT-1:0] st_vld_nxt;
  logic [NUM_CNT-1:0] wptr_r;
  logic [NUM_CNT-1:0] wptr_nxt;
  logic [NUM_CNT-1:0] rptr_r;
  logic [NUM_CNT-1:0] rptr_nxt;
  logic [NUM_CNT-1:0] load_r;
  logic [NUM_CNT-1:0] load_nxt;
  logic [NUM_CNT-1:0] arm_r;
  logic [NUM_CNT-1:0] arm_nxt;
  logic [NUM_CNT-1:0] nullc;

  // ---------------------------------------------------------------------------
  // Host bus front end
  // ---------------------------------------------------------------------------
  // Writes act on the falling edge of the write strobe, reads complete on the
  // end of the read strobe, so a long strobe is still one access.
  always_comb begin
    port        = {I_PORT_SELECT_MSB, I_PORT_SELECT_LSB};
    wr_n_nxt    = I_WR_N | I_CS_N;
    wr_evt      = ~I_CS_N & ~I_WR_N & wr_n_r;
    rd_now      = ~I_CS_N & ~I_RD_N & (port != `PIT_ADDR_CONTROL_WORD_REGISTER);
    rd_act_nxt  = rd_now;
    rd_port_nxt = rd_now ? port : rd_port_r;
    rd_done     = rd_act_r & ~rd_now;
    cw_evt      = wr_evt & (port == `PIT_ADDR_CONTROL_WORD_REGISTER);
    cw_sc       = I_HOST_DATA_BUS[`CW_SC_HI:`CW_SC_LO];
    cw_rw       = rw_t'(I_HOST_DATA_BUS[`CW_RW_HI:`CW_RW_LO]);
    dout_nxt    = `BYTE_ZERO;
    for (int k = 0; k < NUM_CNT; k++) begin
      if (hits(port, k)) begin
        dout_nxt = rbyte[k];
      end
    end
    oe_n_nxt    = ~rd_now;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wr_n_r    <= 1'b1;
      rd_act_r  <= 1'b0;
      rd_port_r <= 2'h0;
      dout_r    <= `BYTE_ZERO;
      oe_n_r    <= 1'b1;
    end else begin
      wr_n_r    <= wr_n_nxt;
      rd_act_r  <= rd_act_nxt;
      rd_port_r <= rd_port_nxt;
      dout_r    <= dout_nxt;
      oe_n_r    <= oe_n_nxt;
    end
  end

  assign O_HOST_DATA_BUS      = dout_r;
  assign O_HOST_DATA_BUS_OE_N = oe_n_r;

  // ---------------------------------------------------------------------------
  // Per-counter registers
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : gen_cnt
      logic own_cw;
      logic own_latch;
      logic rb_count;
      logic rb_status;
      logic own_wr;
      logic own_rd;
      rw_t  fmt;

      always_comb begin
        fmt       = rw_t'(ctl_r[g][`CW_RW_HI:`CW_RW_LO]);
        own_cw    = cw_evt & hits(cw_sc, g) & (cw_rw != RW_LATCH);
        own_latch = cw_evt & hits(cw_sc, g) & (cw_rw == RW_LATCH);
        rb_count  = cw_evt & (cw_sc == `CW_SC_READBACK) & I_HOST_DATA_BUS[`RB_SEL_LO + g]
                    & ~I_HOST_DATA_BUS[`RB_NO_COUNT_BIT];
        rb_status = cw_evt & (cw_sc == `CW_SC_READBACK) & I_HOST_DATA_BUS[`RB_SEL_LO + g]
                    & ~I_HOST_DATA_BUS[`RB_NO_STATUS_BIT];
        own_wr    = wr_evt & hits(port, g);
        own_rd    = rd_done & hits(rd_port_r, g);
        ctl_nxt[g]     = ctl_r[g];
        cr_nxt[g]      = cr_r[g];
        ol_nxt[g]      = latched_r[g] ? ol_r[g] : cnt[g];
        st_nxt[g]      = st_r[g];
        latched_nxt[g] = latched_r[g];
        st_vld_nxt[g]  = st_vld_r[g];
        wptr_nxt[g]    = wptr_r[g];
        rptr_nxt[g]    = rptr_r[g];
        load_nxt[g]    = 1'b0;
        arm_nxt[g]     = own_cw;
        if (own_cw) begin
          ctl_nxt[g]     = I_HOST_DATA_BUS[`CW_CFG_HI:`CW_CFG_LO];
          cr_nxt[g]      = `COUNT_RESET;
          latched_nxt[g] = 1'b0;
          st_vld_nxt[g]  = 1'b0;
          wptr_nxt[g]    = 1'b0;
          rptr_nxt[g]    = 1'b0;
        end
        if (rb_status && !st_vld_r[g]) begin
          st_vld_nxt[g] = 1'b1;
          st_nxt[g]     = {O_OUT[g], nullc[g], ctl_r[g]};
        end
        if (own_wr) begin
          case (fmt)
            RW_LSB: begin
              cr_nxt[g]   = {`BYTE_ZERO, I_HOST_DATA_BUS};
              load_nxt[g] = 1'b1;
            end
            RW_MSB: begin
              cr_nxt[g]   = {I_HOST_DATA_BUS, `BYTE_ZERO};
              load_nxt[g] = 1'b1;
            end
            RW_LH: begin
              if (!wptr_r[g]) begin
                cr_nxt[g][7:0] = I_HOST_DATA_BUS;
              end else begin
                cr_nxt[g][15:8] = I_HOST_DATA_BUS;
                load_nxt[g]     = 1'b1;
              end
              wptr_nxt[g] = ~wptr_r[g];
            end
            default: begin
              cr_nxt[g] = cr_r[g];
            end
          endcase
        end
        if (own_rd) begin
          if (st_vld_r[g]) begin
            st_vld_nxt[g] = 1'b0;
          end else if (fmt == RW_LH && !rptr_r[g]) begin
            rptr_nxt[g] = 1'b1;
          end else begin
            rptr_nxt[g]    = 1'b0;
            latched_nxt[g] = 1'b0;
          end
        end
        // A latch request wins over a read that completes in the same cycle only if the counter is not already latched.
        if ((own_latch || rb_count) && !latched_r[g]) begin
          latched_nxt[g] = 1'b1;
          ol_nxt[g]      = cnt[g];
        end
        // Only one byte of the latch is offered per read.
        if (st_vld_r[g]) begin
          rbyte[g] = st_r[g];
        end else begin
          rbyte[g] = pick(ol_r[g], fmt == RW_MSB || (fmt == RW_LH && rptr_r[g]));
        end
      end

      always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          ctl_r[g]     <= `CTL_RESET;
          cr_r[g]      <= `COUNT_RESET;
          ol_r[g]      <= `COUNT_RESET;
          st_r[g]      <= `BYTE_ZERO;
          latched_r[g] <= 1'b0;
          st_vld_r[g]  <= 1'b0;
          wptr_r[g]    <= 1'b0;
          rptr_r[g]    <= 1'b0;
          load_r[g]    <= 1'b0;
          arm_r[g]     <= 1'b0;
        end else begin
          ctl_r[g]     <= ctl_nxt[g];
          cr_r[g]      <= cr_nxt[g];
          ol_r[g]      <= ol_nxt[g];
          st_r[g]      <= st_nxt[g];
          latched_r[g] <= latched_nxt[g];
          st_vld_r[g]  <= st_vld_nxt[g];
          wptr_r[g]    <= wptr_nxt[g];
          rptr_r[g]    <= rptr_nxt[g];
          load_r[g]    <= load_nxt[g];
          arm_r[g]     <= arm_nxt[g];
        end
      end

      // The load pulse is registered so the element sees the updated count register.
      pit_element u_elem (
        .i_clk     (I_CLK),
        .i_rstn    (I_RSTN),
        .i_cnt_clk (I_CNT_CLK[g]),
        .i_gate    (I_GATE[g]),
        .i_arm     (arm_r[g]),
        .i_load    (load_r[g]),
        .i_cr      (cr_r[g]),
        .o_count   (cnt[g]),
        .o_out     (O_OUT[g]),
        .o_null    (nullc[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence s_cnt_wr(logic [1:0] p, logic [1:0] f);
    wr_evt && port == p && ctl_r[p][`CW_RW_HI:`CW_RW_LO] == f;
  endsequence

  sequence s_cw0;
    cw_evt && I_HOST_DATA_BUS[7:6] == 2'h0 && I_HOST_DATA_BUS[5:4] != 2'h0;
  endsequence

  ctrl_store_a: assert property (s_cw0 |=> ctl_r[0] == $past(I_HOST_DATA_BUS[5:0]))
    else $error("control word not stored");
  cs_gate_a: assert property (I_CS_N |=> O_HOST_DATA_BUS_OE_N)
    else $error("data driven without chip select");
  ctrl_noread_a: assert property (port == 2'h3 |=> O_HOST_DATA_BUS_OE_N)
    else $error("control register was read");
  cnt_indep_a: assert property (cw_evt && I_HOST_DATA_BUS[7:6] == 2'h1 |=> $stable(ctl_r[0]))
    else $error("counter 0 changed by counter 1 word");
  latch_grab_a: assert property (cw_evt && I_HOST_DATA_BUS[7:4] == 4'h0 && !latched_r[0]
    |=> latched_r[0] && ol_r[0] == $past(cnt[0]) ##1 $stable(ctl_r[0]))
    else $error("latch command did not freeze count");
  latch_hold_a: assert property (latched_r[0] && !rd_done && !cw_evt |=> $stable(ol_r[0]))
    else $error("latched value moved");
  one_byte_a: assert property (s_cnt_wr(2'h2, 2'h1) |=> cr_r[2][15:8] == 8'h00 && load_r[2])
    else $error("unwritten byte not zero");
  ptr_pair_a: assert property (s_cnt_wr(2'h0, 2'h3) && !wptr_r[0]
    |=> wptr_r[0] && !load_r[0] && cr_r[0][15:8] == $past(cr_r[0][15:8]))
    else $error("first byte handled wrong");
  null_set_a: assert property ($rose(load_r[0]) |=> nullc[0] || $past(arm_r[0]))
    else $error("count transfer not pending");
  read_byte_a: assert property (rd_now && port == 2'h2 && !st_vld_r[2] && !latched_r[2]
    && !cw_evt && ctl_r[2][5:4] == 2'h1 |=> O_HOST_DATA_BUS == $past(ol_r[2][7:0]))
    else $error("read byte not from output latch");
endmodule

// file: verif/pit_host.sv
`timescale 1ns/1ps

module pit_host (
  input  wire logic           i_clk,
  input  wire pit_pkg::byte_t i_data,
  input  wire logic           i_oe_n,
  output logic                o_cs_n,
  output logic                o_rd_n,
  output logic                o_wr_n,
  output logic [1:0]          o_port,
  output pit_pkg::byte_t      o_data
);
  import pit_pkg::*;

  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_port = 2'h0;
    o_data = 8'h5a;
  end

  // ---------------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------------
  // Write strobe low only for control words and counts, for exactly one taken edge.
  task automatic wr(input logic [1:0] port, input byte_t data, input logic sel);
    @(posedge i_clk);
    o_cs_n <= ~sel;
    o_wr_n <= 1'b0;
    o_port <= port;
    o_data <= data;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
    // A released bus must not keep showing the last byte.
    o_data <= ~data;
    @(posedge i_clk);
  endtask

  // Read strobe low for one read of the given port, counter or control; data taken while still asserted.
  task automatic rd(input logic [1:0] port, input logic sel, output byte_t data, output logic oe_n);
    @(posedge i_clk);
    o_cs_n <= ~sel;
    o_rd_n <= 1'b0;
    o_port <= port;
    @(posedge i_clk);
    @(posedge i_clk);
    data = i_data;
    oe_n = i_oe_n;
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    @(posedge i_clk);
    @(posedge i_clk);
  endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import pit_pkg::*;

  logic       clk;
  logic       rstn;
  logic [2:0] cnt_clk;
  logic [2:0] gate;
  logic [2:0] out;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [1:0] port;
  byte_t      host_data;
  byte_t      dev_data;
  byte_t      bus;
  logic       oe_n;
  byte_t      rdata;
  logic       roe_n;
  int         mismatches;
  int         cmp_count;

  // Wire level of the shared data bus.
  assign bus = (oe_n === 1'b0) ? dev_data : host_data;

  initial clk = 1'b0;
  always #50 clk = ~clk;

  pit_top u_pit_top (
    .I_CLK                (clk),
    .I_RSTN               (rstn),
    .I_CS_N               (cs_n),
    .I_RD_N               (rd_n),
    .I_WR_N               (wr_n),
    .I_PORT_SELECT_LSB    (port[0]),
    .I_PORT_SELECT_MSB    (port[1]),
    .I_HOST_DATA_BUS      (bus),
    .O_HOST_DATA_BUS      (dev_data),
    .O_HOST_DATA_BUS_OE_N (oe_n),
    .I_CNT_CLK            (cnt_clk),
    .I_GATE               (gate),
    .O_OUT                (out)
  );

  pit_host u_pit_host (
    .i_clk  (clk),
    .i_data (bus),
    .i_oe_n (oe_n),
    .o_cs_n (cs_n),
    .o_rd_n (rd_n),
    .o_wr_n (wr_n),
    .o_port (port),
    .o_data (host_data)
  );

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] p, input byte_t d);
    u_pit_host.wr(p, d, 1'b1);
  endtask

  task automatic rdc(input logic [1:0] p, input byte_t exp);
    u_pit_host.rd(p, 1'b1, rdata, roe_n);
    check({7'h0, roe_n}, 8'h00);
    check(rdata, exp);
  endtask

  // The counter clocks are sampled by the system clock, so each phase lasts several cycles.
  task automatic tick(input logic [2:0] m);
    cnt_clk <= m;
    repeat (4) @(posedge clk);
    cnt_clk <= 3'h0;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("BAD t=%0t watchdog expired", $time);
    finish_test;
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    mismatches = 0;
    cmp_count = 0;
    rstn = 1'b0;
    cnt_clk = 3'h0;
    gate = 3'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    check({7'h0, oe_n}, 8'h01);
    // Counter 0 in low-then-high format, control word first.
    wr(2'h3, 8'h30);
    wr(2'h0, 8'h34);
    wr(2'h0, 8'h12);
    tick(3'b001);
    rdc(2'h0, 8'h34);
    rdc(2'h0, 8'h12);
    // Control words in reverse order, one-byte formats.
    wr(2'h3, 8'h90);
    wr(2'h3, 8'h60);
    wr(2'h1, 8'hcd);
    wr(2'h2, 8'h02);
    tick(3'b110);
    check({7'h0, out[2]}, 8'h00);
    rdc(2'h1, 8'hcd);
    rdc(2'h2, 8'h02);
    rdc(2'h0, 8'h34);
    rdc(2'h0, 8'h12);
    // Low-only count of 2 must expire after two ticks, so its high byte is zero.
    gate <= 3'b100;
    tick(3'b100);
    tick(3'b100);
    check({7'h0, out[2]}, 8'h01);
    check({7'h0, out[0]}, 8'h00);
    // A new count waits in the count register until a counter clock moves it.
    wr(2'h3, 8'h60);
    wr(2'h1, 8'h11);
    rdc(2'h1, 8'hcd);
    tick(3'b010);
    rdc(2'h1, 8'h11);
    // Latch command freezes counter 0, then it follows again.
    gate <= 3'b101;
    tick(3'b001);
    tick(3'b001);
    tick(3'b001);
    wr(2'h3, 8'h00);
    tick(3'b001);
    tick(3'b001);
    rdc(2'h0, 8'h31);
    rdc(2'h0, 8'h12);
    rdc(2'h0, 8'h2f);
    rdc(2'h0, 8'h12);
    // Read-back of status for counter 0, then the count.
    wr(2'h3, 8'he2);
    rdc(2'h0, 8'h30);
    rdc(2'h0, 8'h2f);
    rdc(2'h0, 8'h12);
    // Deselected accesses leave everything alone.
    u_pit_host.wr(2'h3, 8'h10, 1'b0);
    wr(2'h3, 8'he2);
    rdc(2'h0, 8'h30);
    rdc(2'h0, 8'h2f);
    rdc(2'h0, 8'h12);
    // Read-back count latch for counter 0 holds the old count across a tick.
    wr(2'h3, 8'hd2);
    tick(3'b001);
    rdc(2'h0, 8'h2f);
    rdc(2'h0, 8'h12);
    rdc(2'h0, 8'h2e);
    u_pit_host.rd(2'h0, 1'b0, rdata, roe_n);
    check({7'h0, roe_n}, 8'h01);
    u_pit_host.rd(2'h3, 1'b1, rdata, roe_n);
    check({7'h0, roe_n}, 8'h01);
    finish_test;
  end
endmodule
